// *** rtl/uart_async_sim_channel.sv ***
// asynchronous serial channel with smart-card and line options
//
// Overview of operation
// - buffers hold characters in bits 0-6, 0-7 or 0-8 per length.
// - output idles high, or floats in open-drain, until transfer starts.
// - third channel output is always open-drain; drive type bit stays zero.
// - clock select zero makes clock pin a port; one takes external clock except on third channel.
// - flow pin is port when disabled, else CTS input or RTS output.
// - first channel CTS may come from shared alternate pin via route bits.
// - transmit starts only when enabled and buffer holds written data.
// - receive starts only when enabled and a start bit is seen.
// - data-logic select inverts characters on buffer write and read.
// - inversion touches character bits only, not start parity stop.
// - polarity reversal inverts every level on output and input.
// - on third channel, output and input compared at the transmit mid-bit tick; mismatch raises IRQ.
// - transmit IRQ on shift finish, or on buffer load into shifter when done select is clear; receive IRQ on buffer load.
// - overrun overwrites receive buffer and leaves receive IRQ alone.
// - error summary set on any overrun, framing or parity error.
// - bit rate is prescaled clock over sixteen times value plus one.
// - on third channel, receiving with error signal on, parity error drives output low.
// - with error signal on, transmit-done IRQ comes half bit later.
// - I2C select remaps source 10 to start/stop, 15 to missing ack.
`timescale 1ns/10ps
`include "uart_defs.svh"
module uart_async_sim_channel #(
    parameter bit THIRD_CHANNEL = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // configuration
    input wire logic async_mode_sel,
    input wire uart_pkg::cfg_type cfg,
    input wire logic [1:0] clk_src_sel,
    input wire logic [7:0] brg_value,
    input wire logic tx_enable,
    input wire logic rx_enable,
    // shared-pin flow routing
    input wire logic cts_route_bit,
    input wire logic clock_multiplex_bit,
    input wire logic peer_cts_input_mode,
    input wire logic alt_cts_in,
    output logic cts_route_active,
    // character interface
    input wire logic tx_write,
    input wire logic [8:0] tx_data,
    input wire logic rx_read,
    output logic [8:0] rx_data,
    // status
    output logic tx_buf_empty,
    output logic tx_shift_empty,
    output logic rx_complete,
    output uart_pkg::err_type rx_err,
    // interrupt requests
    output logic tx_irq,
    output logic rx_irq,
    output logic irq_src10,
    output logic irq_src15,
    input wire logic i2c_nack_event,
    // serial pins
    output logic serial_data_out_pin_o,
    output logic serial_data_out_pin_oe,
    input wire logic serial_data_in_pin,
    input wire logic transfer_clock_pin_i,
    output logic transfer_clock_pin_o,
    output logic transfer_clock_pin_oe,
    input wire logic clk_port_o,
    input wire logic clk_port_oe,
    input wire logic flow_pin_i,
    output logic flow_pin_o,
    output logic flow_pin_oe,
    input wire logic flow_port_o,
    input wire logic flow_port_oe
);
    uart_pkg::tx_state_type tx_state_q;
    uart_pkg::rx_state_type rx_state_q;
    logic tick, ext_mode, clk_pin_q, rx_prev_q, rx_line, cts_ok;
    logic [8:0] tx_buf_q, tx_sh_q, rx_sh_q;
    logic [3:0] tx_tick_q, tx_cnt_q, rx_tick_q, rx_cnt_q, nbits;
    logic tx_level_q, tx_par_q, rx_par_q, rx_perr_q, tx_done_q;
    logic tx_load, tx_bit_end, rx_bit_end, rx_sample, rx_load;
    logic [4:0] err_cnt_q;
    logic err_drive, pin_level, collision, start_stop;

    function automatic logic [3:0] char_bits(uart_pkg::char_len_type l);
        unique case (l)
            uart_pkg::CHAR7: char_bits = `BITS_CHAR7;
            uart_pkg::CHAR9: char_bits = `BITS_CHAR9;
            default: char_bits = `BITS_CHAR8;
        endcase
    endfunction : char_bits

    // inversion mask covers the character field only
    function automatic logic [8:0] char_mask(uart_pkg::cfg_type c);
        unique case (c.char_len)
            uart_pkg::CHAR7: char_mask = `MASK_CHAR7;
            uart_pkg::CHAR9: char_mask = `MASK_CHAR9;
            default: char_mask = `MASK_CHAR8;
        endcase
    endfunction : char_mask

    function automatic logic [8:0] order(logic [8:0] d,
                                          uart_pkg::cfg_type c);
        logic [8:0] r;
        r = d;
        if (c.msb_first && c.char_len == uart_pkg::CHAR8) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end
        order = r;
    endfunction : order

    assign nbits = char_bits(cfg.char_len);
    // third channel has no external clock in async mode
    assign ext_mode = cfg.ext_clk && !THIRD_CHANNEL;
    assign rx_line = serial_data_in_pin ^ cfg.pol_rev;

    bit_rate_gen u_brg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .src_sel(clk_src_sel),
        .ext_mode(ext_mode),
        .ext_edge(transfer_clock_pin_i && !clk_pin_q),
        .brg_value(brg_value),
        .tick(tick)
    );

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_pin_q <= 1'b0;
            rx_prev_q <= 1'b1;
        end else begin
            clk_pin_q <= transfer_clock_pin_i;
            rx_prev_q <= rx_line;
        end
    end

    // clock pin: port or external clock input
    always_comb begin
        transfer_clock_pin_o = clk_port_o;
        transfer_clock_pin_oe = ext_mode ? 1'b0 : clk_port_oe;
    end

    // flow pin and shared CTS routing
    assign cts_route_active = cts_route_bit && !clock_multiplex_bit &&
        peer_cts_input_mode && !cfg.flow_disable && cfg.flow_rts;
    always_comb begin
        flow_pin_o = flow_port_o;
        flow_pin_oe = flow_port_oe;
        cts_ok = 1'b1;
        if (!cfg.flow_disable) begin
            if (cfg.flow_rts) begin
                flow_pin_o = !(rx_enable && !rx_complete);
                flow_pin_oe = 1'b1;
                if (cts_route_active) begin
                    cts_ok = !alt_cts_in;
                end
            end else begin
                flow_pin_oe = 1'b0;
                cts_ok = !flow_pin_i;
            end
        end
    end

    // transmit buffer
    assign tx_load = (tx_state_q == uart_pkg::TX_IDLE) && tick &&
        async_mode_sel && tx_enable && !tx_buf_empty && cts_ok;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_buf_q <= `RST_BUF;
            tx_buf_empty <= 1'b1;
        end else if (tx_write) begin
            tx_buf_q <= (tx_data ^ (cfg.data_inv ? char_mask(cfg)
                : 9'h000)) & char_mask(cfg);
            tx_buf_empty <= 1'b0;
        end else if (tx_load) begin
            tx_buf_empty <= 1'b1;
        end
    end

    // transmit shifter
    assign tx_bit_end = tick && (tx_tick_q == `TICKS_PER_BIT);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_q <= uart_pkg::TX_IDLE;
            tx_tick_q <= 4'h0;
            tx_cnt_q <= 4'h0;
            tx_sh_q <= `RST_BUF;
            tx_level_q <= 1'b1;
            tx_par_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            if (tick && tx_state_q != uart_pkg::TX_IDLE) begin
                tx_tick_q <= tx_tick_q + 4'h1;
            end
            unique case (tx_state_q)
                uart_pkg::TX_IDLE: begin
                    tx_level_q <= 1'b1;
                    if (tx_load) begin
                        tx_sh_q <= order(tx_buf_q, cfg);
                        tx_state_q <= uart_pkg::TX_START;
                        tx_tick_q <= 4'h0;
                        tx_cnt_q <= 4'h0;
                        tx_par_q <= 1'b0;
                        tx_level_q <= 1'b0;
                    end
                end
                uart_pkg::TX_START: begin
                    if (tx_bit_end) begin
                        tx_state_q <= uart_pkg::TX_DATA;
                        tx_level_q <= tx_sh_q[0];
                        tx_par_q <= tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                    end
                end
                uart_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (tx_cnt_q == nbits - 4'h1) begin
                            tx_cnt_q <= 4'h0;
                            if (cfg.parity_en) begin
                                tx_state_q <= uart_pkg::TX_PAR;
                                tx_level_q <= tx_par_q ^ cfg.parity_odd;
                            end else begin
                                tx_state_q <= uart_pkg::TX_STOP;
                                tx_level_q <= 1'b1;
                            end
                        end else begin
                            tx_level_q <= tx_sh_q[0];
                            tx_par_q <= tx_par_q ^ tx_sh_q[0];
                            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                        end
                    end
                end
                uart_pkg::TX_PAR: begin
                    if (tx_bit_end) begin
                        tx_state_q <= uart_pkg::TX_STOP;
                        tx_level_q <= 1'b1;
                    end
                end
                uart_pkg::TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (!cfg.two_stop || tx_cnt_q != 4'h0) begin
                            tx_tick_q <= 4'h0;
                            if (cfg.err_sig_en) begin
                                tx_state_q <= uart_pkg::TX_HOLD;
                            end else begin
                                tx_state_q <= uart_pkg::TX_IDLE;
                                tx_done_q <= 1'b1;
                            end
                        end
                    end
                end
                uart_pkg::TX_HOLD: begin
                    // extra half bit lets software sample the card's answer
                    if (tick && tx_tick_q == `HALF_BIT_TICKS) begin
                        tx_state_q <= uart_pkg::TX_IDLE;
                        tx_done_q <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign tx_shift_empty = (tx_state_q == uart_pkg::TX_IDLE);

    // receiver
    assign rx_bit_end = tick && (rx_tick_q == `TICKS_PER_BIT);
    assign rx_sample = tick && (rx_tick_q == `SAMPLE_TICK);
    assign rx_load = rx_sample && (rx_state_q == uart_pkg::RX_STOP);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_q <= uart_pkg::RX_IDLE;
            rx_tick_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_sh_q <= `RST_BUF;
            rx_par_q <= 1'b0;
            rx_perr_q <= 1'b0;
        end else begin
            if (tick) begin
                rx_tick_q <= rx_tick_q + 4'h1;
            end
            unique case (rx_state_q)
                uart_pkg::RX_IDLE: begin
                    if (async_mode_sel && rx_enable && rx_prev_q &&
                        !rx_line) begin
                        rx_state_q <= uart_pkg::RX_START;
                        rx_tick_q <= 4'h0;
                        rx_cnt_q <= 4'h0;
                        rx_par_q <= 1'b0;
                        rx_perr_q <= 1'b0;
                    end
                end
                uart_pkg::RX_START: begin
                    if (rx_sample && rx_line) begin
                        rx_state_q <= uart_pkg::RX_IDLE; // glitch, not start
                    end else if (rx_bit_end) begin
                        rx_state_q <= uart_pkg::RX_DATA;
                    end
                end
                uart_pkg::RX_DATA: begin
                    if (rx_sample) begin
                        rx_sh_q <= {rx_line, rx_sh_q[8:1]};
                        rx_par_q <= rx_par_q ^ rx_line;
                    end
                    if (rx_bit_end) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == nbits - 4'h1) begin
                            rx_state_q <= cfg.parity_en ? uart_pkg::RX_PAR
                                : uart_pkg::RX_STOP;
                        end
                    end
                end
                uart_pkg::RX_PAR: begin
                    if (rx_sample) begin
                        rx_perr_q <= rx_line ^ rx_par_q ^ cfg.parity_odd;
                    end
                    if (rx_bit_end) begin
                        rx_state_q <= uart_pkg::RX_STOP;
                    end
                end
                uart_pkg::RX_STOP: begin
                    // only the first stop bit is checked
                    if (rx_sample) begin
                        rx_state_q <= uart_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // receive buffer and error flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_data <= `RST_BUF;
            rx_complete <= 1'b0;
            rx_err <= '0;
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= 1'b0;
            if (rx_load) begin
                rx_data <= (order(rx_sh_q >> (4'h9 - nbits), cfg) ^
                    (cfg.data_inv ? char_mask(cfg) : 9'h000)) &
                    char_mask(cfg);
                rx_complete <= 1'b1;
                rx_irq <= !rx_complete;
                if (rx_complete) begin
                    rx_err.overrun <= 1'b1;
                end
                if (!rx_line) begin
                    rx_err.framing <= 1'b1;
                end
                if (rx_perr_q) begin
                    rx_err.parity <= 1'b1;
                end
                if (rx_complete || !rx_line || rx_perr_q) begin
                    rx_err.sum <= 1'b1;
                end
            end else begin
                if (rx_read) begin
                    rx_complete <= 1'b0;
                end
                // errors clear when reception is disabled
                if (!rx_enable) begin
                    rx_err <= '0;
                end
            end
        end
    end

    // parity error signal: low for one bit starting half a bit later
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_cnt_q <= 5'h00;
        end else if (rx_sample && rx_state_q == uart_pkg::RX_PAR &&
                     cfg.err_sig_en && THIRD_CHANNEL &&
                     (rx_line ^ rx_par_q ^ cfg.parity_odd)) begin
            err_cnt_q <= 5'h01;
        end else if (tick && err_cnt_q != 5'h00) begin
            err_cnt_q <= (err_cnt_q == `ERR_SIG_END) ? 5'h00
                : err_cnt_q + 5'h01;
        end
    end
    assign err_drive = (err_cnt_q >= `ERR_SIG_START);

    // output pin: open-drain releases for high
    assign pin_level = (tx_level_q && !err_drive) ^ cfg.pol_rev;
    always_comb begin
        serial_data_out_pin_o = 1'b0;
        serial_data_out_pin_oe = 1'b0;
        if (async_mode_sel) begin
            if (THIRD_CHANNEL || cfg.output_drive_type_bit) begin
                serial_data_out_pin_oe = !pin_level;
            end else begin
                serial_data_out_pin_o = pin_level;
                serial_data_out_pin_oe = 1'b1;
            end
        end
    end

    // collision check at the transmit mid-bit tick, not the transfer clock pin
    // written out in full: a function reading module state would hide
    // those signals from the assignment's sensitivity
    assign collision = THIRD_CHANNEL && tick &&
        (tx_tick_q == `SAMPLE_TICK) && (tx_state_q != uart_pkg::TX_IDLE) &&
        (pin_level != serial_data_in_pin);
    assign start_stop = transfer_clock_pin_i &&
        (rx_prev_q != rx_line);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_irq <= 1'b0;
            irq_src10 <= 1'b0;
            irq_src15 <= 1'b0;
        end else begin
            tx_irq <= cfg.tx_irq_done ? tx_done_q : tx_load;
            irq_src10 <= cfg.i2c_sel ? start_stop : collision;
            irq_src15 <= cfg.i2c_sel ? i2c_nack_event
                : (cfg.tx_irq_done ? tx_done_q : tx_load);
        end
    end
endmodule : uart_async_sim_channel

// *** rtl/uart_defs.svh ***
// timing counts, field values and reset values for the serial channel
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
`define TICKS_PER_BIT 4'hf
`define SAMPLE_TICK 4'h7
`define HALF_BIT_TICKS 4'h7
`define ERR_SIG_START 5'h09
`define ERR_SIG_END 5'h18
`define DIV1_TOP 5'h00
`define DIV2_TOP 5'h01
`define DIV8_TOP 5'h07
`define DIV32_TOP 5'h1f
`define BITS_CHAR7 4'h7
`define BITS_CHAR8 4'h8
`define BITS_CHAR9 4'h9
`define MASK_CHAR7 9'h07f
`define MASK_CHAR8 9'h0ff
`define MASK_CHAR9 9'h1ff
`define RST_BUF 9'h000
`endif

// *** rtl/uart_pkg.sv ***
// types shared by the serial channel files
package uart_pkg;
    typedef enum logic [1:0] {
        CHAR7 = 2'h0,
        CHAR8 = 2'h1,
        CHAR9 = 2'h2
    } char_len_type;

    typedef struct packed {
        char_len_type char_len;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic msb_first;
        logic data_inv;
        logic pol_rev;
        logic err_sig_en;
        logic tx_irq_done;
        logic ext_clk;
        logic flow_disable;
        logic flow_rts;
        logic output_drive_type_bit;
        logic i2c_sel;
    } cfg_type;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic parity;
        logic sum;
    } err_type;

    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_START = 6'h02,
        TX_DATA = 6'h04,
        TX_PAR = 6'h08,
        TX_STOP = 6'h10,
        TX_HOLD = 6'h20
    } tx_state_type;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } rx_state_type;
endpackage : uart_pkg

// *** rtl/bit_rate_gen.sv ***
// bit rate generator: prescaler then divide by value plus one
`timescale 1ns/10ps
`include "uart_defs.svh"
module bit_rate_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // source selection
    input wire logic [1:0] src_sel,
    input wire logic ext_mode,
    input wire logic ext_edge,
    input wire logic [7:0] brg_value,
    // sixteen times the bit rate
    output logic tick
);
    logic [4:0] pre_q;
    logic [7:0] div_q;
    logic [4:0] pre_top;
    logic src_pulse;

    always_comb begin
        unique case (src_sel)
            2'h0: pre_top = `DIV1_TOP;
            2'h1: pre_top = `DIV2_TOP;
            2'h2: pre_top = `DIV8_TOP;
            2'h3: pre_top = `DIV32_TOP;
        endcase
    end

    assign src_pulse = ext_mode ? ext_edge : (pre_q >= pre_top);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= 5'h00;
        end else if (ext_mode || pre_q >= pre_top) begin
            pre_q <= 5'h00;
        end else begin
            pre_q <= pre_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 8'h00;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_pulse) begin
                if (div_q >= brg_value) begin
                    div_q <= 8'h00;
                    tick <= 1'b1;
                end else begin
                    div_q <= div_q + 8'h01;
                end
            end
        end
    end
endmodule : bit_rate_gen

// *** testbench/uart_async_sim_channel_sva.sv ***
// port assertions for the serial channel
`timescale 1ns/10ps
module uart_chk (
    // clock, reset and settings
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire uart_pkg::cfg_type cfg,
    input wire logic tx_enable,
    input wire logic i2c_nack_event,
    input wire logic flow_port_oe,
    // status, requests and pins
    input wire logic tx_buf_empty,
    input wire logic tx_shift_empty,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire uart_pkg::err_type rx_err,
    input wire logic irq_src10,
    input wire logic irq_src15,
    input wire logic serial_data_out_pin_oe,
    input wire logic flow_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    start_gate_a: assert property ($fell(tx_shift_empty) |->
        $past(tx_enable) && !$past(tx_buf_empty)) else $error("bad start");
    // settings changes may take a cycle to reach the pin
    idle_float_a: assert property (tx_shift_empty && $stable(cfg) &&
        !cfg.pol_rev && !cfg.err_sig_en && !cfg.i2c_sel
        |-> !serial_data_out_pin_oe) else $error("idle pin driven");
    tx_done_a: assert property ($rose(tx_shift_empty) &&
        cfg.tx_irq_done && !cfg.err_sig_en |-> ##[0:2] tx_irq)
        else $error("no transmit request");
    overrun_quiet_a: assert property ($rose(rx_err.overrun) |->
        !rx_irq ##1 !rx_irq) else $error("receive request on overrun");
    err_sum_a: assert property (rx_err.overrun || rx_err.framing ||
        rx_err.parity |-> ##[0:1] rx_err.sum) else $error("sum flag low");
    bus_collide_a: assert property (irq_src10 && !cfg.i2c_sel |->
        !$past(tx_shift_empty)) else $error("collision while idle");
    nack_map_a: assert property (cfg.i2c_sel && i2c_nack_event |=>
        irq_src15) else $error("source 15 not remapped");
    flow_port_a: assert property (cfg.flow_disable && $stable(cfg) |->
        flow_pin_oe == flow_port_oe) else $error("flow pin not a port");
endmodule : uart_chk
bind uart_async_sim_channel uart_chk chk (.ref_clk, .sys_rst, .cfg,
    .tx_enable, .i2c_nack_event, .flow_port_oe, .tx_buf_empty,
    .tx_shift_empty, .tx_irq, .rx_irq, .rx_err, .irq_src10, .irq_src15,
    .serial_data_out_pin_oe, .flow_pin_oe);

// *** testbench/uart_peer.sv ***
// remote serial peer: sends frames and decodes the channel output
`timescale 1ns/10ps
module uart_peer (
    // clock
    input wire logic ref_clk,
    // lines
    input wire logic line_in,
    output logic line_out
);
    // prescale 2, value 0: (1+1)*(0+1)*16 clocks a bit
    int bc = 32;
    initial line_out = 1'b1;
    task send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_out = f[i];
            repeat (bc) @(negedge ref_clk);
        end
        line_out = 1'b1;
    endtask : send
    // samples at bit centres counted from the start edge
    task recv(output logic [11:0] f, input int n);
        f = 12'h000;
        @(negedge line_in);
        repeat (bc / 2) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            f[i] = line_in;
            repeat (bc) @(negedge ref_clk);
        end
    endtask : recv
endmodule : uart_peer

// *** testbench/test_uart_async_sim_channel.sv ***
// self-checking bench for the serial channel
`timescale 1ns/10ps
module test_uart_async_sim_channel;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic async_mode_sel, tx_enable, rx_enable, tx_write, rx_read;
    logic cts_route_bit, clock_multiplex_bit, peer_cts_input_mode;
    logic i2c_nack_event, serial_data_in_pin, flow_port_o, flow_port_oe;
    logic tx_buf_empty, tx_shift_empty, rx_complete, tx_irq, rx_irq;
    logic irq_src10, irq_src15, serial_data_out_pin_o;
    logic serial_data_out_pin_oe, line;
    logic [1:0] clk_src_sel;
    logic [7:0] brg_value;
    logic [8:0] tx_data, rx_data;
    uart_pkg::cfg_type cfg;
    uart_pkg::err_type rx_err;
    int err_count = 0;
    int n_checks = 0;
    int ntx = 0;
    int nrx = 0;
    int ncol = 0;
    always #20 ref_clk = ~ref_clk;
    // open drain with pull-up: only a driven low pulls the line down
    assign line = !(serial_data_out_pin_oe && !serial_data_out_pin_o);
    always @(posedge ref_clk) begin
        ntx <= ntx + int'(tx_irq);
        nrx <= nrx + int'(rx_irq);
        ncol <= ncol + int'(irq_src10);
    end
    uart_async_sim_channel dut (.ref_clk, .sys_rst, .async_mode_sel, .cfg,
        .clk_src_sel, .brg_value, .tx_enable, .rx_enable, .cts_route_bit,
        .clock_multiplex_bit, .peer_cts_input_mode, .alt_cts_in(1'b0),
        .cts_route_active(), .tx_write, .tx_data, .rx_read, .rx_data,
        .tx_buf_empty, .tx_shift_empty, .rx_complete, .rx_err, .tx_irq,
        .rx_irq, .irq_src10, .irq_src15, .i2c_nack_event,
        .serial_data_out_pin_o, .serial_data_out_pin_oe, .serial_data_in_pin,
        .transfer_clock_pin_i(1'b0), .transfer_clock_pin_o(),
        .transfer_clock_pin_oe(), .clk_port_o(1'b0), .clk_port_oe(1'b0),
        .flow_pin_i(1'b0), .flow_pin_o(), .flow_pin_oe(), .flow_port_o,
        .flow_port_oe);
    uart_peer peer (.ref_clk, .line_in(line), .line_out(serial_data_in_pin));
    task chk(input string s, input logic [11:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // one character out; hold keeps transmit disabled for two bits first
    task automatic t_tx(input logic [8:0] d, input int nb, input bit hold);
        logic [11:0] f;
        logic [8:0] w;
        int k;
        k = ntx;
        w = (cfg.data_inv ? ~d : d) & (9'h1ff >> (9 - nb));
        if (cfg.msb_first) w[7:0] = {<<{w[7:0]}};
        fork
            peer.recv(f, nb + 3);
            begin
                tx_enable = !hold;
                tx_data = d;
                tx_write = 1'b1;
                @(negedge ref_clk);
                tx_write = 1'b0;
                repeat (2 * peer.bc) @(negedge ref_clk);
                chk("shift idle", 12'({tx_shift_empty, tx_buf_empty}), 12'({hold, !hold}));
                tx_enable = 1'b1;
            end
        join
        repeat (peer.bc) @(negedge ref_clk);
        chk("frame", f, (12'(w) << 1) |
            (12'({1'b1, ^w ^ cfg.parity_odd}) << (nb + 1)));
        chk("tx irq", 12'(ntx - k), 12'h001);
    endtask : t_tx
    // one character in; the out line is sampled at the stop bit centre
    task automatic t_rx(input logic [7:0] d, input bit bad,
        input logic [3:0] e, input int irq);
        logic l;
        int k;
        k = nrx;
        fork
            peer.send({2'b11, ^d ^ cfg.parity_odd ^ bad, d, 1'b0}, 12);
            begin
                repeat (10 * peer.bc + peer.bc / 2) @(negedge ref_clk);
                l = line;
            end
        join
        chk("fault line", 12'(l), 12'(!(bad && cfg.err_sig_en)));
        chk("rx data", 12'(rx_data), 12'(d ^ 8'hff));
        chk("rx irq", 12'(nrx - k), 12'(irq));
        chk("rx err", 12'(rx_err), 12'(e));
    endtask : t_rx
    initial begin
        async_mode_sel = 1'b1;
        {tx_enable, rx_enable, tx_write, rx_read, i2c_nack_event} = '0;
        {cts_route_bit, clock_multiplex_bit, peer_cts_input_mode} = 3'h5;
        {flow_port_o, flow_port_oe} = 2'h3;
        clk_src_sel = 2'h1;
        brg_value = 8'h00;
        tx_data = 9'h000;
        cfg = '0;
        cfg.parity_en = 1'b1;
        cfg.tx_irq_done = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        rx_enable = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cfg.char_len = uart_pkg::char_len_type'(i);
            t_tx(9'h1a5 ^ 9'(i), 7 + i, i == 1);
        end
        chk("collision", 12'(ncol != 0), 12'h001);
        cfg.char_len = uart_pkg::CHAR8;
        cfg.flow_disable = 1'b1;
        cfg.parity_odd = 1'b1;
        cfg.data_inv = 1'b1;
        cfg.msb_first = 1'b1;
        t_tx(9'h0c3, 8, 1'b0);
        cfg.msb_first = 1'b0;
        cfg.err_sig_en = 1'b1;
        t_rx(8'h3c, 1'b0, 4'h0, 1);
        t_rx(8'ha5, 1'b1, 4'hb, 0);
        rx_read = 1'b1;
        rx_enable = 1'b0;
        @(negedge ref_clk);
        rx_read = 1'b0;
        peer.send(12'hffe, 12);
        chk("rx off", 12'({rx_complete, rx_err}), 12'h000);
        cfg.err_sig_en = 1'b0;
        cfg.pol_rev = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("idle reversed", 12'(line), 12'h000);
        cfg.pol_rev = 1'b0;
        cfg.i2c_sel = 1'b1;
        i2c_nack_event = 1'b1;
        @(negedge ref_clk);
        i2c_nack_event = 1'b0;
        cfg.i2c_sel = 1'b0;
        repeat (4) @(negedge ref_clk);
        test_done;
    end
    // the whole run needs well under a fifth of this
    initial begin
        #1ms;
        err_count++;
        test_done;
    end
endmodule : test_uart_async_sim_channel
